// ### pkg/mode_sense_cfg.svh
// constants of the bus mode sense qualifier: timing, widths, reset values
`ifndef MODE_SENSE_CFG_SVH
`define MODE_SENSE_CFG_SVH

// clock rate in hertz (20 ns period)
`define MS_CLK_HZ        50000000
// qualification time in milliseconds, used for all three hold periods
`define MS_HOLD_MS       100
// qualification time in clock cycles, a least time rounded up
`define MS_QUAL_CYCLES   (((`MS_CLK_HZ / 1000) * `MS_HOLD_MS + 0) / 1)
// counter width, wide enough for the cycle count above
`define MS_CNT_W         23
// reset value of the qualification counter
`define MS_CNT_RST       23'h000000
// reset value of the comparator synchroniser stages
`define MS_CMP_RST       4'h0

`endif

// ### pkg/mode_sense_pkg.sv
// types shared by the bus mode sense qualifier
`include "mode_sense_cfg.svh"

package mode_sense_pkg;

  // bus transmission mode, as decoded or as qualified
  typedef enum logic [1:0] {
    MODE_SE,
    MODE_LVD,
    MODE_HVD,
    MODE_IND
  } mode_t;

  // power-on sequencing phase
  typedef enum logic [1:0] {
    PH_POWERUP,
    PH_SETTLE,
    PH_RUN
  } phase_t;

  // comparator results of the mode sense receiver, one bit per threshold
  typedef struct packed {
    logic hvd_lo;   // line at or above 2.4 V
    logic lvd_hi;   // line above 1.9 V
    logic lvd_lo;   // line at or above 0.7 V
    logic se_hi;    // line above 0.5 V
  } cmp_t;

  // qualified status handed to the rest of the device
  typedef struct packed {
    mode_t mode;     // qualified bus mode
    logic  valid;    // qualified mode is in force
    logic  drv_en;   // signal drivers may leave high impedance
    logic  gnd_en;   // ground drivers on
    logic  change;   // one-cycle pulse on a qualified mode change
  } status_t;

  typedef logic [`MS_CNT_W-1:0] cnt_t;

  // complete state of the qualifier
  typedef struct packed {
    cmp_t    s1;      // synchroniser stage one
    cmp_t    s2;      // synchroniser stage two
    cmp_t    s3;      // synchroniser stage three
    cmp_t    filt;    // accepted comparator levels
    phase_t  phase;   // power-on sequencing phase
    mode_t   cand;    // mode currently being timed
    cnt_t    cnt;     // cycles the candidate has held
    status_t out;     // registered outputs
  } state_t;

endpackage : mode_sense_pkg

// ### design/bus_mode_sense_qualifier.sv
// bus mode sense qualifier: decodes and time-qualifies the bus mode
module bus_mode_sense_qualifier
  import mode_sense_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES = `MS_QUAL_CYCLES  // hold time in cycles
) (
  input  wire logic    clk,     // 50 MHz device clock
  input  wire logic    rst_n,   // asynchronous power-on reset, active low
  input  wire cmp_t    cmp_in,  // raw comparator results from the line
  output status_t      status   // qualified mode and driver enables
);

  // one count serves the power-on, settle and switch holds; a hold thus
  // lasts at least QUAL_CYCLES cycles, a cycle more when timing a new mode
  localparam cnt_t CNT_LAST = cnt_t'(QUAL_CYCLES - 1);  // final count

  state_t st_r;    // registered state
  state_t st_nxt;  // next state
  mode_t  dec;     // decoded mode of the accepted levels

  // map the four threshold bits onto a mode; odd patterns are indeterminate
  function automatic mode_t decode_mode(input cmp_t c);
    mode_t m;
    m = MODE_IND;
    unique case (c)
      4'b0000: m = MODE_SE;
      4'b0011: m = MODE_LVD;
      4'b1111: m = MODE_HVD;
      default: m = MODE_IND;
    endcase
    return m;
  endfunction : decode_mode

  // decode from the filtered levels only, never from a raw stage
  always_comb begin
    dec = decode_mode(st_r.filt);
  end

  // next-state logic: synchroniser, sequencing, qualification, outputs
  always_comb begin
    st_nxt = st_r;
    st_nxt.out.change = 1'b0;
    // three-stage synchroniser; stage one feeds only stage two
    st_nxt.s1 = cmp_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // a bit is accepted once stages two and three agree
    for (int i = 0; i < 4; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
    unique case (st_r.phase)
      PH_POWERUP: begin
        if (st_r.cnt == CNT_LAST) begin
          st_nxt.phase = PH_SETTLE;
          st_nxt.cnt   = '0;
          st_nxt.cand  = dec;
        end else begin
          st_nxt.cnt = st_r.cnt + cnt_t'(1);
        end
      end
      PH_SETTLE, PH_RUN: begin
        // restart timing on any change or indeterminate level
        if (dec == MODE_IND || dec != st_r.cand) begin
          st_nxt.cand = dec;
          st_nxt.cnt  = '0;
        end else if (st_r.cnt != CNT_LAST) begin
          st_nxt.cnt = st_r.cnt + cnt_t'(1);
        end else if (st_r.phase == PH_SETTLE) begin
          st_nxt.phase     = PH_RUN;
          st_nxt.out.mode  = st_r.cand;
          st_nxt.out.valid = 1'b1;
        end else if (st_r.cand != st_r.out.mode) begin
          // new mode held long enough: adopt it
          st_nxt.out.mode   = st_r.cand;
          st_nxt.out.change = 1'b1;
        end
      end
      default: begin
        // an illegal phase code falls back to the power-on hold
        st_nxt.phase = PH_POWERUP;
        st_nxt.cnt   = '0;
      end
    endcase
    // signal drivers off before qualification and under HVD
    st_nxt.out.drv_en = (st_nxt.phase == PH_RUN) &&
                        (st_nxt.out.mode != MODE_HVD);
    // ground drivers follow a qualified single-ended bus
    st_nxt.out.gnd_en = (st_nxt.phase == PH_RUN) &&
                        (st_nxt.out.mode == MODE_SE);
  end

  // state register; outputs are fields of it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.s1     <= `MS_CMP_RST;
      st_r.s2     <= `MS_CMP_RST;
      st_r.s3     <= `MS_CMP_RST;
      st_r.filt   <= `MS_CMP_RST;
      st_r.phase  <= PH_POWERUP;
      st_r.cand   <= MODE_IND;
      st_r.cnt    <= `MS_CNT_RST;
      st_r.out    <= '{mode: MODE_IND, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // qualified mode reported to the device
  assign status = st_r.out;

  // checks on sequencing, decode and driver enables
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_hiz_before_run: assert property (
    st_r.phase != PH_RUN |-> !status.drv_en && !status.valid)
    else $error("drivers enabled before qualification");

  chk_powerup_length: assert property (
    $past(st_r.phase) == PH_POWERUP && st_r.phase == PH_SETTLE
      |-> $past(st_r.cnt) == CNT_LAST)
    else $error("power-on hold ended early");

  chk_settle_release: assert property (
    $rose(status.valid) |-> $past(st_r.phase) == PH_SETTLE &&
      $past(st_r.cnt) == CNT_LAST && status.mode == $past(st_r.cand))
    else $error("released without stable mode");

  chk_switch_after_hold: assert property (
    $past(st_r.phase) == PH_RUN && $changed(status.mode)
      |-> $past(st_r.cnt) == CNT_LAST && status.change)
    else $error("mode switched without full hold");

  chk_decode_bands: assert property (
    st_r.filt == 4'b0011 |-> dec == MODE_LVD)
    else $error("middle band not decoded as lvd");

  chk_decode_se: assert property (
    st_r.filt == 4'b0000 |-> dec == MODE_SE)
    else $error("low band not decoded as se");

  chk_decode_hvd: assert property (
    st_r.filt == 4'b1111 |-> dec == MODE_HVD)
    else $error("high band not decoded as hvd");

  chk_gap_indet: assert property (
    st_r.filt == 4'b0001 || st_r.filt == 4'b0111 |-> dec == MODE_IND)
    else $error("gap level decoded as a mode");

  chk_hvd_all_off: assert property (
    status.mode == MODE_HVD |-> !status.drv_en && !status.gnd_en)
    else $error("drivers on under hvd");

  chk_gnd_drv_se: assert property (
    status.valid && status.mode == MODE_SE |-> status.gnd_en)
    else $error("ground drivers off in se mode");

  chk_timer_restart: assert property (
    st_r.phase != PH_POWERUP && (dec == MODE_IND || dec != st_r.cand)
      |=> st_r.cnt == '0)
    else $error("timer not restarted");

  chk_ind_no_switch: assert property (
    dec == MODE_IND |=> !status.change)
    else $error("mode switched on indeterminate level");

  chk_valid_sticky: assert property (
    status.valid |=> status.valid)
    else $error("qualified mode withdrawn");

  chk_mode_defined: assert property (
    status.valid |-> status.mode != MODE_IND)
    else $error("qualified mode is indeterminate");

  chk_change_pulse: assert property (
    status.change |=> !status.change)
    else $error("change pulse longer than one cycle");

  chk_drv_released: assert property (
    status.valid && status.mode != MODE_HVD |-> status.drv_en)
    else $error("drivers held off in a driven mode");

  chk_gnd_only_se: assert property (
    status.gnd_en |-> status.valid && status.mode == MODE_SE)
    else $error("ground drivers on outside se");

  chk_sync_accept: assert property (
    st_r.s2 == st_r.s3 |=> st_r.filt == $past(st_r.s3))
    else $error("agreed comparator level not accepted");

  cov_release: cover property ($rose(status.valid));
  cov_mode_change: cover property (status.change);
  cov_hvd_run: cover property (status.valid && status.mode == MODE_HVD);
  cov_restart: cover property (st_r.phase == PH_RUN && dec == MODE_IND);
  cov_cut_short: cover property (st_r.phase == PH_RUN &&
    st_r.cand != status.mode && dec != st_r.cand);

endmodule : bus_mode_sense_qualifier

// ### dv/sense_line.sv
// model of the shared mode sense line and its receiver comparators
module sense_line
  import mode_sense_pkg::*;
(
  input  int   mv_lvl,  // line level set by terminators, in mV
  output cmp_t cmp_out  // comparator results seen by the device
);
  timeunit 1ns;
  timeprecision 1ns;
  // band thresholds
  // edges are exact here, so boundary levels decode repeatably
  assign cmp_out = '{hvd_lo: mv_lvl >= 2400, lvd_hi: mv_lvl > 1900,
                     lvd_lo: mv_lvl >= 700,  se_hi: mv_lvl > 500};
endmodule : sense_line

// ### dv/tb.sv
// self-checking bench of the bus mode sense qualifier
module tb
  import mode_sense_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 8;               // shortened hold time
  localparam int LV[4] = '{200, 1300, 3000, 600};  // a level per mode
  localparam int CRN[7] = '{500, 700, 1900, 2400, 2399, 699, 2100};
  logic    clk;         // 50 MHz clock
  logic    rst_n;       // reset, active low
  int      mv;          // line level in mV
  cmp_t    cmp;         // comparator results
  status_t st;          // qualifier outputs
  int      num_errors;  // mismatches
  int      n_tests;     // comparisons
  int      n_chg;       // change pulses seen in a trial
  int      t;           // cycle counter
  mode_t   cur;         // expected qualified mode

  sense_line sense_line_i (.mv_lvl(mv), .cmp_out(cmp));
  bus_mode_sense_qualifier #(.QUAL_CYCLES(Q)) bus_mode_sense_qualifier_i (
    .clk(clk), .rst_n(rst_n), .cmp_in(cmp), .status(st));

  // expected decode of a line level
  function automatic mode_t exp_mode(int v);
    if (v <= 500) return MODE_SE;
    if (v < 700 || (v > 1900 && v < 2400)) return MODE_IND;
    return (v <= 1900) ? MODE_LVD : MODE_HVD;
  endfunction : exp_mode

  task automatic chk_mode(string nm, mode_t e, mode_t g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_mode

  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit

  // compare a count of events
  task automatic chk_num(string nm, int e, int g);
    n_tests++;
    if (g != e) begin
      num_errors++;
      $display("[FAIL] %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_num

  // drive a level at an edge, then count change pulses for n cycles
  task automatic hold(int v, int n);
    @(posedge clk);
    mv <= v;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (st.change === 1'b1) n_chg++;
    end
  endtask : hold

  // outputs expected once mode e is qualified
  task automatic chk_out(mode_t e);
    chk_mode("mode", e, st.mode);
    chk_bit("valid", 1'b1, st.valid);
    chk_bit("drv_en", e != MODE_HVD, st.drv_en);
    chk_bit("gnd_en", e == MODE_SE, st.gnd_en);
  endtask : chk_out

  // one level, held past the qualify time or cut short
  task automatic trial(int v, bit long_hold);
    mode_t m;
    int    e;
    m = exp_mode(v);
    n_chg = 0;
    e = (long_hold && m != MODE_IND && m != cur) ? 1 : 0;
    if (long_hold) begin
      hold(v, Q + 8);
      if (m != MODE_IND) cur = m;
    end else begin
      // short run must not qualify, even if followed by the old mode
      hold(v, Q - 4);
      hold(LV[cur], Q + 8);
    end
    chk_num("change_pulses", e, n_chg);
    chk_out(cur);
  endtask : trial

  // release reset at an edge, then wait boundedly for the first qualified mode
  task automatic power_up(mode_t e);
    rst_n <= 1'b1;
    t = 0;
    while (st.valid !== 1'b1 && t < 100) begin
      @(posedge clk);
      #1;
      t++;
      if (st.valid !== 1'b1) chk_bit("hiz", 1'b0, st.drv_en);
    end
    chk_bit("hold_time", 1'b1, t >= 2 * Q && t <= 2 * Q + 8);
    chk_out(e);
  endtask : power_up

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    mv = 0;
    num_errors = 0;
    n_tests = 0;
    cur = MODE_SE;
    void'($urandom(32'h820296fa));
    repeat (8) @(posedge clk);
    chk_mode("rst_mode", MODE_IND, st.mode);
    // drivers stay off through both power-on holds
    power_up(MODE_SE);
    // a timed-out power-up skips straight to the verdict
    if (t < 100) begin
      foreach (CRN[i]) trial(CRN[i], 1'b1);
      repeat (40) trial($urandom_range(3200), $urandom_range(1));
      // reset in mid-run drops everything at once
      @(posedge clk);
      rst_n <= 1'b0;
      mv <= LV[MODE_LVD];
      #1;
      chk_bit("rst_valid", 1'b0, st.valid);
      chk_bit("rst_drv", 1'b0, st.drv_en);
      repeat (2) @(posedge clk);
      // second power-up on a middle-band line qualifies lvd
      power_up(MODE_LVD);
    end
    print_verdict();
  end
endmodule : tb
